// file: hdl/safety_fault_supervisor.sv
// Safety fault supervisor: processor error capture and I/O module recovery
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ns
// Contract
// RULE1: Any processor diagnostic error enters error state, all safety outputs go safe.
// RULE2: After power is reapplied, self-test runs before any normal operation.
// RULE3: Cause codes 5af1..5af4: sequence, address, comparison, real-time clock faults.
// RULE4: Cause codes 5af5..5af8: dual init, watchdog, 8-hour memory check, RAM.
// RULE5: Two detail words follow the cause word with extra fault detail.
// RULE6: With autostart, a persisting fault after restart re-enters error and stops.
// RULE7: Operator withholds the application to read diagnostic words after a fault.
// RULE8: A faulty channel goes safe while other channels keep operating.
// RULE9: Each detected channel fault is visible in readable status registers.
// RULE10: Module fault forces safe state, then reset, restart and self-test.
// RULE11: Passing self-test resumes normal operation and commanded outputs.
// RULE12: Failing self-test resets again and repeats the sequence.
// RULE13: A hot-swapped module starts automatically after successful self-test.
// RULE14: Application must tolerate an I/O module restarting on its own.
// RULE15: Safe output state is logic 0, regardless of configured timeout state.
// RULE16: Cause word survives power cycle and self-test for later reading.
module safety_fault_supervisor
  import fault_sup_pkg::*;
#(
  parameter int     NUM_CH     = 8,
  parameter int     RESET_CYC  = MOD_RESET_CYC,
  parameter longint MEMCHK_MAX = MEMCHK_CYC
) (
  // APB
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Power and diagnostics pins
  input  wire logic              power_good,
  input  wire logic [7:0]        cpu_diag_err,
  input  wire logic              memchk_active,
  input  wire logic [15:0]       diag_detail_a_in,
  input  wire logic [15:0]       diag_detail_b_in,
  input  wire logic [NUM_CH-1:0] ch_fault_in,
  input  wire logic              mod_fault_in,
  input  wire logic              selftest_ok_in,
  input  wire logic              module_present,
  // Outputs
  output logic [NUM_CH-1:0]      safety_out,
  output logic                   cpu_running,
  output logic                   cpu_error,
  output logic                   module_reset_n,
  output logic                   irq
);
  typedef enum logic [3:0] {
    CPU_TEST  = 4'b0001,
    CPU_STOP  = 4'b0010,
    CPU_RUN   = 4'b0100,
    CPU_ERROR = 4'b1000
  } cpu_state_t;

  typedef enum logic [3:0] {
    MOD_RESET = 4'b0001,
    MOD_TEST  = 4'b0010,
    MOD_RUN   = 4'b0100,
    MOD_SAFE  = 4'b1000
  } mod_state_t;

  // Priority encoder of diagnostic lines to cause code
  function automatic logic [15:0] cause_of(input logic [7:0] e);
    logic [15:0] c;
    c = CAUSE_NONE;
    if      (e[0]) c = CAUSE_SEQ;
    else if (e[1]) c = CAUSE_ADDR;
    else if (e[2]) c = CAUSE_CMP;
    else if (e[3]) c = CAUSE_RTC;
    else if (e[4]) c = CAUSE_DUALINIT;
    else if (e[5]) c = CAUSE_WDOG;
    else if (e[6]) c = CAUSE_MEMTIME;
    else if (e[7]) c = CAUSE_RAM;
    return c;
  endfunction

  // Input synchronisers
  logic [7:0]        diag_s1_ff, diag_s2_ff;
  logic [NUM_CH-1:0] chf_s1_ff, chf_s2_ff;
  logic [4:0]        misc_s1_ff, misc_s2_ff;
  logic [15:0]       det_a_s1_ff, det_a_s2_ff, det_b_s1_ff, det_b_s2_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_s1_ff <= '0;
      diag_s2_ff <= '0;
      chf_s1_ff  <= '0;
      chf_s2_ff  <= '0;
      misc_s1_ff <= '0;
      misc_s2_ff <= '0;
      det_a_s1_ff <= '0;
      det_a_s2_ff <= '0;
      det_b_s1_ff <= '0;
      det_b_s2_ff <= '0;
    end else begin
      diag_s1_ff <= cpu_diag_err;
      diag_s2_ff <= diag_s1_ff;
      chf_s1_ff  <= ch_fault_in;
      chf_s2_ff  <= chf_s1_ff;
      misc_s1_ff <= {power_good, memchk_active, mod_fault_in, selftest_ok_in,
                     module_present};
      misc_s2_ff <= misc_s1_ff;
      // Same depth as the diagnostic lines, so detail and cause stay aligned
      det_a_s1_ff <= diag_detail_a_in;
      det_a_s2_ff <= det_a_s1_ff;
      det_b_s1_ff <= diag_detail_b_in;
      det_b_s2_ff <= det_b_s1_ff;
    end
  end
  logic pwr_ok, memchk_on, mod_fault, st_ok, present;
  assign {pwr_ok, memchk_on, mod_fault, st_ok, present} = misc_s2_ff;

  // Registers
  cpu_state_t            cpu_ff;
  mod_state_t            mod_ff;
  logic [15:0]           cause_ff, detail_a_ff, detail_b_ff;
  logic [2:0]            ctrl_ff;
  logic [IRQ_WIDTH-1:0]  irq_stat_ff, irq_mask_ff;
  logic [NUM_CH-1:0]     ch_fault_ff, out_cmd_ff;
  logic [7:0]            retries_ff;
  logic [15:0]           rst_cnt_ff;
  logic [47:0]           memchk_cnt_ff;
  logic                  pwr_prev_ff, present_prev_ff;
  logic [31:0]           prdata_ff;

  // APB decode
  logic wr_en, rd_en;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  logic addr_ok;
  assign addr_ok = (paddr <= OFS_RETRIES) && (paddr[1:0] == 2'b00);
  assign pslverr = psel & penable & ~addr_ok;

  // Memory check run time guard, overrun raises its own diagnostic
  logic memchk_over;
  assign memchk_over = memchk_cnt_ff >= 48'(MEMCHK_MAX);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      memchk_cnt_ff <= '0;
    else if (!memchk_on)
      memchk_cnt_ff <= '0;
    else if (!memchk_over)
      memchk_cnt_ff <= memchk_cnt_ff + 48'd1;
  end

  logic [7:0] diag_all;
  assign diag_all = {diag_s2_ff[7], diag_s2_ff[6] | memchk_over, diag_s2_ff[5:0]};
  logic       any_diag;
  assign any_diag = |diag_all;

  // Power cycle detection: a rising power_good means power was reapplied
  logic pwr_rise;
  assign pwr_rise = pwr_ok & ~pwr_prev_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_prev_ff     <= 1'b0;
      present_prev_ff <= 1'b0;
    end else begin
      pwr_prev_ff     <= pwr_ok;
      present_prev_ff <= present;
    end
  end

  // Processor self-test engine
  logic cpu_st_start, cpu_st_busy, cpu_st_done, cpu_st_pass;
  assign cpu_st_start = (cpu_ff == CPU_TEST) & ~cpu_st_busy & ~cpu_st_done & pwr_ok;
  self_test_seq #(.TEST_CYC(SELFTEST_CYC)) u_cpu_test (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (cpu_st_start),
    .test_ok (~any_diag),
    .busy    (cpu_st_busy),
    .done    (cpu_st_done),
    .pass    (cpu_st_pass)
  );

  // Processor state machine
  cpu_state_t nxt_cpu;
  always_comb begin
    nxt_cpu = cpu_ff;
    case (cpu_ff)
      CPU_TEST: begin
        if (!pwr_ok)
          nxt_cpu = CPU_STOP;
        else if (cpu_st_done && !cpu_st_pass)
          nxt_cpu = CPU_ERROR; // RULE6
        else if (cpu_st_done)
          nxt_cpu = ctrl_ff[CTRL_AUTOSTART] ? CPU_RUN : CPU_STOP;
      end
      CPU_STOP: begin
        if (pwr_rise)
          nxt_cpu = CPU_TEST; // RULE2
        else if (any_diag)
          nxt_cpu = CPU_ERROR;
        else if (ctrl_ff[CTRL_RUN_REQ] && pwr_ok)
          nxt_cpu = CPU_RUN;
      end
      CPU_RUN: begin
        if (any_diag)
          nxt_cpu = CPU_ERROR; // RULE1
        else if (!pwr_ok)
          nxt_cpu = CPU_STOP;
      end
      CPU_ERROR: begin
        // Only a power cycle leaves the error state
        if (pwr_rise)
          nxt_cpu = CPU_TEST; // RULE2
      end
      default: nxt_cpu = CPU_ERROR;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cpu_ff <= CPU_TEST;
    else
      cpu_ff <= nxt_cpu;
  end

  // Error capture; not cleared by power cycle or self-test
  logic cpu_err_entry;
  assign cpu_err_entry = (nxt_cpu == CPU_ERROR) && (cpu_ff != CPU_ERROR);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_ff    <= CAUSE_NONE;
      detail_a_ff <= 16'h0000;
      detail_b_ff <= 16'h0000;
    end else if (cpu_err_entry) begin
      cause_ff    <= cause_of(diag_all); // RULE3 RULE4 RULE16
      detail_a_ff <= det_a_s2_ff;        // RULE5
      detail_b_ff <= det_b_s2_ff;        // RULE5
    end
  end

  // Settling wait: the module result needs time to cross the synchroniser,
  // otherwise every test would see the stale reset-time result and fail
  logic [1:0] settle_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      settle_ff <= 2'b00;
    else if (mod_ff != MOD_TEST)
      settle_ff <= 2'b00;
    else if (settle_ff != 2'b11)
      settle_ff <= settle_ff + 2'b01;
  end

  // I/O module self-test engine
  logic mod_st_start, mod_st_busy, mod_st_done, mod_st_pass;
  assign mod_st_start = (mod_ff == MOD_TEST) & (settle_ff == 2'b11) & ~mod_st_busy
                        & ~mod_st_done;
  self_test_seq #(.TEST_CYC(SELFTEST_CYC)) u_mod_test (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (mod_st_start),
    .test_ok (st_ok),
    .busy    (mod_st_busy),
    .done    (mod_st_done),
    .pass    (mod_st_pass)
  );

  // I/O module state machine
  logic mod_fault_any, insert;
  assign mod_fault_any = mod_fault | ctrl_ff[CTRL_MOD_FAULT];
  assign insert = present & ~present_prev_ff;
  logic rst_done;
  assign rst_done = rst_cnt_ff == 16'(RESET_CYC - 1);
  mod_state_t nxt_mod;
  always_comb begin
    nxt_mod = mod_ff;
    case (mod_ff)
      MOD_SAFE: begin
        if (present)
          nxt_mod = MOD_RESET; // RULE10
      end
      MOD_RESET: begin
        if (!present)
          nxt_mod = MOD_SAFE;
        else if (rst_done)
          nxt_mod = MOD_TEST; // RULE10
      end
      MOD_TEST: begin
        if (!present)
          nxt_mod = MOD_SAFE;
        else if (mod_st_done && mod_st_pass)
          nxt_mod = MOD_RUN; // RULE11 RULE13
        else if (mod_st_done)
          nxt_mod = MOD_RESET; // RULE12
      end
      MOD_RUN: begin
        if (!present || mod_fault_any)
          nxt_mod = MOD_SAFE; // RULE10
        else if (insert)
          nxt_mod = MOD_RESET;
      end
      default: nxt_mod = MOD_SAFE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mod_ff <= MOD_SAFE;
    else
      mod_ff <= nxt_mod;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rst_cnt_ff <= 16'h0000;
    else if (mod_ff != MOD_RESET)
      rst_cnt_ff <= 16'h0000;
    else if (!rst_done)
      rst_cnt_ff <= rst_cnt_ff + 16'h0001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      retries_ff <= 8'h00;
    else if (mod_ff == MOD_RUN)
      retries_ff <= 8'h00;
    else if (mod_ff == MOD_TEST && mod_st_done && !mod_st_pass && retries_ff != 8'hff)
      retries_ff <= retries_ff + 8'h01; // RULE12
  end

  // Sticky channel faults, cleared by writing one; a new fault wins
  logic ch_wr;
  assign ch_wr = wr_en && paddr == OFS_CH_FAULT;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ch_fault_ff <= '0;
    else
      ch_fault_ff <= (ch_fault_ff & ~(ch_wr ? pwdata[NUM_CH-1:0] : '0)) | chf_s2_ff; // RULE9
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff     <= 3'b000;
      irq_mask_ff <= '0;
      out_cmd_ff  <= '0;
    end else if (wr_en) begin
      case (paddr)
        OFS_CTRL:     ctrl_ff     <= pwdata[2:0];
        OFS_IRQ_MASK: irq_mask_ff <= pwdata[IRQ_WIDTH-1:0];
        OFS_OUT_CMD:  out_cmd_ff  <= pwdata[NUM_CH-1:0];
        default:      ctrl_ff     <= ctrl_ff;
      endcase
    end
  end

  // Interrupt status; set beats write-one-to-clear
  logic [IRQ_WIDTH-1:0] irq_evt;
  assign irq_evt = {(mod_ff == MOD_TEST) && mod_st_done && mod_st_pass,
                    (nxt_mod == MOD_SAFE) && (mod_ff == MOD_RUN),
                    |(chf_s2_ff & ~ch_fault_ff),
                    cpu_err_entry};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_stat_ff <= '0;
    else if (wr_en && paddr == OFS_IRQ_STAT)
      irq_stat_ff <= (irq_stat_ff & ~pwdata[IRQ_WIDTH-1:0]) | irq_evt;
    else
      irq_stat_ff <= irq_stat_ff | irq_evt;
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // Read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata_ff <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_CAUSE:    prdata_ff <= {16'h0000, cause_ff};
        OFS_DETAIL_A: prdata_ff <= {16'h0000, detail_a_ff};
        OFS_DETAIL_B: prdata_ff <= {16'h0000, detail_b_ff};
        OFS_CTRL:     prdata_ff <= {29'h0, ctrl_ff};
        OFS_STATUS:   prdata_ff <= {24'h0, mod_ff, cpu_ff};
        OFS_IRQ_STAT: prdata_ff <= {28'h0, irq_stat_ff};
        OFS_IRQ_MASK: prdata_ff <= {28'h0, irq_mask_ff};
        OFS_CH_FAULT: prdata_ff <= 32'(ch_fault_ff);
        OFS_OUT_CMD:  prdata_ff <= 32'(out_cmd_ff);
        OFS_RETRIES:  prdata_ff <= {24'h0, retries_ff};
        default:      prdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = rd_en ? prdata_ff : 32'h0000_0000;

  // Safety outputs: safe is 0; registered so no glitch reaches the field
  logic [NUM_CH-1:0] nxt_out;
  always_comb begin
    nxt_out = out_cmd_ff & ~chf_s2_ff; // RULE8
    if (cpu_ff != CPU_RUN || nxt_cpu == CPU_ERROR)
      nxt_out = '0; // RULE1 RULE15
    if (mod_ff != MOD_RUN || mod_fault_any)
      nxt_out = '0; // RULE10 RULE15
  end
  logic [NUM_CH-1:0] out_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      out_ff <= '0;
    else
      out_ff <= nxt_out; // RULE11
  end
  assign safety_out     = out_ff;
  assign cpu_running    = cpu_ff == CPU_RUN;
  assign cpu_error      = cpu_ff == CPU_ERROR;
  assign module_reset_n = mod_ff != MOD_RESET;
endmodule

// file: include/fault_sup_pkg.sv
// Package: register map, cause codes, fields and timing for the fault supervisor
package fault_sup_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CAUSE    = 8'h00;
  localparam logic [7:0] OFS_DETAIL_A = 8'h04;
  localparam logic [7:0] OFS_DETAIL_B = 8'h08;
  localparam logic [7:0] OFS_CTRL     = 8'h0c;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_CH_FAULT = 8'h1c;
  localparam logic [7:0] OFS_OUT_CMD  = 8'h20;
  localparam logic [7:0] OFS_RETRIES  = 8'h24;
  // Cause codes, in diagnostic index order 0..7
  localparam logic [15:0] CAUSE_SEQ      = 16'h5af1;
  localparam logic [15:0] CAUSE_ADDR     = 16'h5af2;
  localparam logic [15:0] CAUSE_CMP      = 16'h5af3;
  localparam logic [15:0] CAUSE_RTC      = 16'h5af4;
  localparam logic [15:0] CAUSE_DUALINIT = 16'h5af5;
  localparam logic [15:0] CAUSE_WDOG     = 16'h5af6;
  localparam logic [15:0] CAUSE_MEMTIME  = 16'h5af7;
  localparam logic [15:0] CAUSE_RAM      = 16'h5af8;
  localparam logic [15:0] CAUSE_NONE     = 16'h0000;
  // Control register fields
  localparam int CTRL_RUN_REQ   = 0;
  localparam int CTRL_AUTOSTART = 1;
  localparam int CTRL_MOD_FAULT = 2;
  // Interrupt bit positions
  localparam int IRQ_CPU_ERR  = 0;
  localparam int IRQ_CH_FAULT = 1;
  localparam int IRQ_MOD_ERR  = 2;
  localparam int IRQ_MOD_OK   = 3;
  localparam int IRQ_WIDTH    = 4;
  // Timing
  localparam int CLK_HZ         = 10_000_000;
  localparam int MOD_RESET_NS   = 1000;
  localparam int MOD_RESET_CYC  = (MOD_RESET_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int MEMCHK_HOURS   = 8;
  localparam longint MEMCHK_CYC = longint'(MEMCHK_HOURS) * 3600 * CLK_HZ;
  // Self-test engine length in cycles
  localparam int SELFTEST_CYC   = 16;
endpackage

// file: hdl/self_test_seq.sv
// Power-up self-test sequencer: runs a fixed test, reports pass or fail
`timescale 1ns/1ns
module self_test_seq
  import fault_sup_pkg::*;
#(
  parameter int TEST_CYC = SELFTEST_CYC
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic start,
  input  wire logic test_ok,
  // Result
  output logic      busy,
  output logic      done,
  output logic      pass
);
  logic [7:0] cnt_ff;
  logic       bad_ff;
  logic       busy_ff;
  logic       done_ff;
  logic       pass_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= 8'h00;
      bad_ff  <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      pass_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start && !busy_ff) begin
        busy_ff <= 1'b1;
        cnt_ff  <= 8'h00;
        bad_ff  <= 1'b0;
      end else if (busy_ff) begin
        // Any failing sample during the run fails the whole test
        if (!test_ok)
          bad_ff <= 1'b1;
        if (cnt_ff == 8'(TEST_CYC - 1)) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          pass_ff <= ~bad_ff & test_ok;
        end else begin
          cnt_ff <= cnt_ff + 8'h01;
        end
      end
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;
  assign pass = pass_ff;
endmodule

// file: verif/io_module_model.sv
// Behavioural safety I/O module on the far side of the supervisor
`timescale 1ns/1ns
module io_module_model (
  // Clock
  input  wire logic       pclk,
  // From supervisor
  input  wire logic       module_reset_n,
  // Bench controls
  input  wire logic       insert,
  input  wire logic       load,
  input  wire logic [3:0] bad_tests,
  // To supervisor, and start count to the bench
  output logic            selftest_ok_in,
  output logic            module_present,
  output logic [3:0]      starts
);
  logic [3:0] fails_left;
  logic       rst_seen;
  initial begin
    selftest_ok_in = 1'b0;
    module_present = 1'b0;
    starts = 4'h0;
    fails_left = 4'h0;
    rst_seen = 1'b1;
  end
  always @(posedge pclk) begin
    module_present <= insert;
    rst_seen <= module_reset_n;
    if (load) begin
      fails_left <= bad_tests;
    end else if (module_reset_n === 1'b0) begin
      // No valid result while held in reset
      selftest_ok_in <= 1'b0;
    end else if (rst_seen === 1'b0) begin
      starts <= starts + 4'h1;
      if (fails_left != 4'h0) begin
        fails_left <= fails_left - 4'h1;
        selftest_ok_in <= 1'b0;
      end else begin
        selftest_ok_in <= 1'b1;
      end
    end
  end
endmodule

// file: verif/fault_sup_chk.sv
// Checker: port-level timing relations of the fault supervisor
`timescale 1ns/1ns
module fault_sup_chk #(
  parameter int     NUM_CH     = 8,
  parameter int     RESET_CYC  = 10,
  parameter longint MEMCHK_MAX = 50
) (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [7:0]        paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  // Diagnostics and faults
  input wire logic              power_good,
  input wire logic [7:0]        cpu_diag_err,
  input wire logic [NUM_CH-1:0] ch_fault_in,
  input wire logic              mod_fault_in,
  // Outputs
  input wire logic [NUM_CH-1:0] safety_out,
  input wire logic              cpu_running,
  input wire logic              cpu_error,
  input wire logic              module_reset_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int unsigned low_cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt_ff <= 0;
    else if (!module_reset_n) low_cnt_ff <= low_cnt_ff + 1;
    else low_cnt_ff <= 0;
  end
  err_safe_a: assert property (cpu_error |-> safety_out == '0)
    else $error("outputs active in processor error");
  diag_err_a: assert property (cpu_running && cpu_diag_err != 8'h00 |-> ##[1:5] cpu_error)
    else $error("diagnostic error not taken");
  self_test_a: assert property ($rose(power_good) |=> !cpu_running [*8])
    else $error("run before self-test");
  err_hold_a: assert property ($fell(cpu_error) |-> power_good)
    else $error("error state left without power return");
  ch_safe_a: assert property ((ch_fault_in & $past(ch_fault_in, 1) & $past(ch_fault_in, 2)
    & $past(ch_fault_in, 3) & safety_out) == '0) else $error("faulty channel still driven");
  mod_fault_a: assert property ($rose(mod_fault_in) |-> ##[1:6] safety_out == '0)
    else $error("module fault not made safe");
  rst_safe_a: assert property (!module_reset_n |-> safety_out == '0)
    else $error("outputs driven during module reset");
  rst_len_a: assert property ($rose(module_reset_n) |-> low_cnt_ff >= RESET_CYC
    && low_cnt_ff <= RESET_CYC + 1) else $error("module reset length wrong");
  slverr_a: assert property (psel && penable && paddr > 8'h24 |-> pslverr && pready)
    else $error("unmapped access not refused");
endmodule
bind safety_fault_supervisor fault_sup_chk #(.NUM_CH(NUM_CH), .RESET_CYC(RESET_CYC),
  .MEMCHK_MAX(MEMCHK_MAX)) chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .power_good(power_good), .cpu_diag_err(cpu_diag_err), .ch_fault_in(ch_fault_in),
  .mod_fault_in(mod_fault_in), .safety_out(safety_out), .cpu_running(cpu_running),
  .cpu_error(cpu_error), .module_reset_n(module_reset_n));

// file: verif/safety_fault_supervisor_tb_top.sv
// Testbench: APB sequences against the fault supervisor and an I/O module model
`timescale 1ns/1ns
module safety_fault_supervisor_tb_top;
  import fault_sup_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0, cpu_diag_err = 0, ch_fault_in = 0, safety_out;
  logic [31:0] pwdata = 0, prdata, q;
  logic        pready, pslverr, power_good = 0, memchk_active = 0, mod_fault_in = 0, e;
  logic [15:0] detail_a = 0, detail_b = 0;
  logic        selftest_ok_in, module_present, insert = 0, load = 0;
  logic [3:0]  bad_tests = 0, starts, s0;
  logic        cpu_running, cpu_error, module_reset_n, irq;
  int          mismatches = 0, checked = 0;
  always #50 pclk = ~pclk;
  // Memory check limit shortened so the overrun shows within the run
  safety_fault_supervisor #(.NUM_CH(8), .RESET_CYC(10), .MEMCHK_MAX(50)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_good(power_good), .cpu_diag_err(cpu_diag_err), .memchk_active(memchk_active),
    .diag_detail_a_in(detail_a), .diag_detail_b_in(detail_b), .ch_fault_in(ch_fault_in),
    .mod_fault_in(mod_fault_in), .selftest_ok_in(selftest_ok_in),
    .module_present(module_present), .safety_out(safety_out), .cpu_running(cpu_running),
    .cpu_error(cpu_error), .module_reset_n(module_reset_n), .irq(irq));
  io_module_model peer (.pclk(pclk), .module_reset_n(module_reset_n), .insert(insert),
    .load(load), .bad_tests(bad_tests), .selftest_ok_in(selftest_ok_in),
    .module_present(module_present), .starts(starts));
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp,
                        input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(nm, exp & m, q & m);
  endtask
  task automatic wait_st(input logic [7:0] exp, input logic [7:0] m);
    int n;
    n = 0;
    // Polling bounds the wait without assuming a state-change latency
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while ((q[7:0] & m) !== exp && n < 200);
    chk("status", {24'h0, exp}, {24'h0, q[7:0] & m});
  endtask
  task automatic pcycle();
    power_good <= 1'b0;
    repeat (4) @(posedge pclk);
    power_good <= 1'b1;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    wait_st(8'h82, 8'hff);
    rd_chk("cause", OFS_CAUSE, 32'h0, 32'hffff);
    apb(1'b0, 8'h28, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    power_good <= 1'b1;
    wait_st(8'h01, 8'h0f);
    wait_st(8'h02, 8'h0f);
    insert <= 1'b1;
    wait_st(8'h40, 8'hf0);
    chk("outs", 32'h0, {24'h0, safety_out});
    apb(1'b1, OFS_OUT_CMD, 32'hff);
    apb(1'b1, OFS_CTRL, 32'h1);
    wait_st(8'h44, 8'hff);
    chk("outs", 32'hff, {24'h0, safety_out});
    ch_fault_in <= 8'h04;
    repeat (6) @(posedge pclk);
    chk("outs", 32'hfb, {24'h0, safety_out});
    rd_chk("chflt", OFS_CH_FAULT, 32'h04, 32'hff);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_IRQ_MASK, 32'h2);
    @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    ch_fault_in <= 8'h00;
    apb(1'b1, OFS_IRQ_STAT, 32'hf);
    apb(1'b1, OFS_CH_FAULT, 32'hff);
    @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    rd_chk("chflt", OFS_CH_FAULT, 32'h0, 32'hff);
    s0 = starts;
    bad_tests <= 4'h1;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    mod_fault_in <= 1'b1;
    repeat (3) @(posedge pclk);
    mod_fault_in <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("outs", 32'h0, {24'h0, safety_out});
    wait_st(8'h40, 8'hf0);
    chk("starts", {28'h0, s0 + 4'h2}, {28'h0, starts});
    chk("outs", 32'hff, {24'h0, safety_out});
    rd_chk("irqst", OFS_IRQ_STAT, 32'hc, 32'hc);
    apb(1'b1, OFS_IRQ_STAT, 32'hf);
    apb(1'b1, OFS_CTRL, 32'h5);
    rd_chk("irqst", OFS_IRQ_STAT, 32'h4, 32'h4);
    apb(1'b1, OFS_CTRL, 32'h1);
    wait_st(8'h44, 8'hff);
    for (int i = 0; i < 8; i++) begin
      detail_a <= 16'h0a00 + 16'(i);
      detail_b <= 16'h0b00 + 16'(i);
      cpu_diag_err <= 8'h01 << i;
      wait_st(8'h08, 8'h0f);
      chk("outs", 32'h0, {24'h0, safety_out});
      rd_chk("cause", OFS_CAUSE, 32'h5af1 + 32'(i), 32'hffff);
      rd_chk("det_a", OFS_DETAIL_A, 32'h0a00 + 32'(i), 32'hffff);
      rd_chk("det_b", OFS_DETAIL_B, 32'h0b00 + 32'(i), 32'hffff);
      cpu_diag_err <= 8'h00;
      apb(1'b1, OFS_CTRL, 32'h0);
      pcycle();
      wait_st(8'h02, 8'h0f);
      rd_chk("cause", OFS_CAUSE, 32'h5af1 + 32'(i), 32'hffff);
      apb(1'b1, OFS_CTRL, 32'h1);
      wait_st(8'h04, 8'h0f);
    end
    rd_chk("irqst", OFS_IRQ_STAT, 32'h1, 32'h1);
    memchk_active <= 1'b1;
    wait_st(8'h08, 8'h0f);
    rd_chk("cause", OFS_CAUSE, 32'h5af7, 32'hffff);
    memchk_active <= 1'b0;
    cpu_diag_err <= 8'h01;
    apb(1'b1, OFS_CTRL, 32'h3);
    pcycle();
    repeat (40) @(posedge pclk);
    rd_chk("status", OFS_STATUS, 32'h8, 32'hf);
    rd_chk("cause", OFS_CAUSE, 32'h5af1, 32'hffff);
    conclude();
  end
  initial begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    $display("Error watchdog expected finish seen hang");
    conclude();
  end
endmodule
